// >>> src/eeprom_cfg.svh
/*
  Constants of the two-wire serial EEPROM front end: array shape, page
  shape, bus selection code, bit slot counts and write cycle timing.
  Assumes the core clock runs at the period given here.
*/
`ifndef EEPROM_CFG_SVH
`define EEPROM_CFG_SVH

// ==========================================================
// Array and page shape
`define MEM_DEPTH     4096
`define MEM_AW        12
`define PAGE_BYTES    32
`define PAGE_AW       5
`define PAGE_NW       7

// ==========================================================
// Bus selection, bit slots and queue depth
`define DEV_TYPE      4'hA
`define ACK_SLOT      4'h8
`define FIFO_DEPTH    2

// ==========================================================
// Timing: self-timed write, longest time rounds down
`define CLK_PERIOD_NS 10
`define WR_TIME_NS    5000000
`define WR_CYCLES     (`WR_TIME_NS / `CLK_PERIOD_NS)
`define WR_CNT_W      20

`endif

// >>> src/eeprom_pkg.sv
/*
  Types of the two-wire serial EEPROM front end: byte phase, queued
  write entry and the packed state of the core.
  Assumes eeprom_cfg.svh is on the include path.
*/
`include "eeprom_cfg.svh"

package eeprom_pkg;

  // ==========================================================
  // Byte phase of a transfer, Gray coded along the usual path
  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_DEV  = 3'h1,
    PH_AHI  = 3'h3,
    PH_ALO  = 3'h2,
    PH_WR   = 3'h6,
    PH_RD   = 3'h7,
    PH_WAIT = 3'h5
  } phase_e;

  // ==========================================================
  // One written byte on its way to the page latch
  typedef struct packed {
    logic [`MEM_AW-1:0] addr;
    logic [7:0]         data;
  } wr_entry_s;

  // ==========================================================
  // Whole state of the core, registered as one word
  typedef struct packed {
    logic                               scl_s1;
    logic                               scl_s2;
    logic                               scl_d;
    logic                               sda_s1;
    logic                               sda_s2;
    logic                               sda_d;
    logic [2:0]                         strap_s1;
    logic [2:0]                         strap_s2;
    logic                               wg_s1;
    logic                               wg_s2;
    phase_e                             phase;
    logic [3:0]                         bitcnt;
    logic [7:0]                         sh;
    logic [7:0]                         tx;
    logic [`MEM_AW-1:0]                 addr;
    logic                               ack;
    logic                               sda_oe;
    logic                               wr_seen;
    logic                               prog_req;
    logic                               busy;
    logic [`WR_CNT_W-1:0]               wr_cnt;
    logic [`PAGE_NW-1:0]                page;
    logic [`PAGE_BYTES-1:0]             pvalid;
    logic [`PAGE_BYTES-1:0][7:0]        pbuf;
  } core_s;

endpackage

// >>> src/serial_eeprom_bus_pins.sv
/*
  Two-wire serial EEPROM slave: pin synchronisers, start and stop
  detection, byte phases, acknowledge, page latch, self-timed write and
  the 4096 x 8 array, plus a small two-entry queue for written bytes.
  Assumes an external pull-up on the data wire, a bus master on the far
  side and a core clock much faster than the serial clock.
*/
`timescale 1ns/10ps
`include "eeprom_cfg.svh"

// ==========================================================
// Two-entry queue with valid and ready on both sides
module pair_fifo #(
  parameter int W     = 20,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  // Filling side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Draining side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } fifo_s;

  fifo_s st_r;
  fifo_s st_nxt;
  logic  push;
  logic  pop;

  // Handshakes are combinational, data leaves from the storage flops
  assign in_ready_o  = (st_r.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (st_r.cnt != '0);
  assign out_data_o  = st_r.mem[st_r.rp];

  // Pointer and fill count update
  always_comb begin
    st_nxt = st_r;
    push   = in_valid_i && in_ready_o;
    pop    = out_valid_o && out_ready_i;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data_i;
      st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + AW'(1);
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + AW'(1);
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// ==========================================================
// EEPROM slave top
module serial_eeprom_bus_pins
  import eeprom_pkg::*;
#(
  parameter int WR_CYCLES = `WR_CYCLES
) (
  // Core clock and reset
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  // Serial clock, also the clock of the link capture flop
  input  wire logic scl_i,
  // Open-drain data wire
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  // Address straps and write guard
  input  wire logic addr_strap_bit0_i,
  input  wire logic addr_strap_bit1_i,
  input  wire logic addr_strap_bit2_i,
  input  wire logic write_guard_i
);

  // ==========================================================
  // Declarations
  core_s              st_r;
  core_s              st_nxt;
  logic               lk_bit_r;
  logic [7:0]         mem_r [0:`MEM_DEPTH-1];
  logic               mem_we;
  logic [`MEM_AW-1:0] mem_waddr;
  logic [7:0]         mem_wdata;
  logic               scl_rise;
  logic               scl_fall;
  logic               start_evt;
  logic               stop_evt;
  logic               ok;
  logic               f_in_valid;
  logic               f_in_ready;
  wr_entry_s          f_in_data;
  logic               f_out_valid;
  logic               f_out_ready;
  wr_entry_s          f_out_data;

  // ==========================================================
  // Link domain: the data bit is caught right at the clock's rising
  // edge, and held until the next one, so the core reads it safely
  // once its own copy of the clock has risen
  always_ff @(posedge scl_i) begin
    lk_bit_r <= sda_i;
  end

  // ==========================================================
  // Write queue: a stalled page latch makes the queue fill, and a full
  // queue turns the next data byte into a not-acknowledge
  pair_fifo #(
    .W     ($bits(wr_entry_s)),
    .DEPTH (`FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (f_in_valid),
    .in_ready_o  (f_in_ready),
    .in_data_i   (f_in_data),
    .out_valid_o (f_out_valid),
    .out_ready_i (f_out_ready),
    .out_data_o  (f_out_data)
  );

  // ==========================================================
  // Pins: the wire is only pulled low, never driven high
  assign sda_o    = 1'b0;
  assign sda_oe_o = st_r.sda_oe;

  // Edges seen on the synchronised pins; the bus idles with clock high,
  // so a data edge while the clock stays high is a start or a stop
  assign scl_rise  = st_r.scl_s2 && !st_r.scl_d;
  assign scl_fall  = !st_r.scl_s2 && st_r.scl_d;
  assign start_evt = st_r.scl_s2 && st_r.scl_d && st_r.sda_d && !st_r.sda_s2;
  assign stop_evt  = st_r.scl_s2 && st_r.scl_d && !st_r.sda_d && st_r.sda_s2;

  // Queue entry is the current address and the byte just shifted in
  assign f_in_data   = '{addr: st_r.addr, data: st_r.sh};
  assign f_out_ready = !st_r.busy;

  // ==========================================================
  // Core next state
  always_comb begin
    st_nxt     = st_r;
    ok         = 1'b0;
    f_in_valid = 1'b0;
    mem_we     = 1'b0;
    mem_waddr  = '0;
    mem_wdata  = '0;

    // Two flops on every pin; at 100 MHz this oversamples even a
    // 1 MHz serial clock many times per bit
    st_nxt.scl_s1   = scl_i;
    st_nxt.scl_s2   = st_r.scl_s1;
    st_nxt.scl_d    = st_r.scl_s2;
    st_nxt.sda_s1   = sda_i;
    st_nxt.sda_s2   = st_r.sda_s1;
    st_nxt.sda_d    = st_r.sda_s2;
    // Open pins read low through the pad pull-downs
    st_nxt.strap_s1 = {addr_strap_bit2_i, addr_strap_bit1_i, addr_strap_bit0_i};
    st_nxt.strap_s2 = st_r.strap_s1;
    st_nxt.wg_s1    = write_guard_i;
    st_nxt.wg_s2    = st_r.wg_s1;

    // Bus framing and byte phases
    if (start_evt) begin
      st_nxt.phase  = PH_DEV;
      st_nxt.bitcnt = '0;
      st_nxt.sda_oe = 1'b0;
    end else if (stop_evt) begin
      st_nxt.phase   = PH_IDLE;
      st_nxt.sda_oe  = 1'b0;
      st_nxt.wr_seen = 1'b0;
      if (st_r.wr_seen) begin
        st_nxt.prog_req = 1'b1;
      end
    end else if (scl_rise && st_r.phase != PH_IDLE && st_r.phase != PH_WAIT) begin
      if (st_r.bitcnt != `ACK_SLOT) begin
        st_nxt.sh     = {st_r.sh[6:0], lk_bit_r};
        st_nxt.bitcnt = st_r.bitcnt + 4'h1;
      end else begin
        // Ninth clock: leave the acknowledge slot
        st_nxt.bitcnt = '0;
        case (st_r.phase)
          PH_DEV: begin
            if (!st_r.ack) begin
              st_nxt.phase = PH_WAIT;
            end else if (st_r.sh[0]) begin
              // Current address read starts at the held address
              st_nxt.phase = PH_RD;
              st_nxt.tx    = mem_r[st_r.addr];
              st_nxt.addr  = st_r.addr + `MEM_AW'(1);
            end else begin
              st_nxt.phase = PH_AHI;
            end
          end
          PH_AHI: begin
            st_nxt.phase = PH_ALO;
          end
          PH_ALO: begin
            st_nxt.phase = PH_WR;
          end
          PH_WR: begin
            if (!st_r.ack) begin
              st_nxt.phase = PH_WAIT;
            end
          end
          PH_RD: begin
            // Master low in the slot asks for the next location
            if (lk_bit_r) begin
              st_nxt.phase = PH_WAIT;
            end else begin
              st_nxt.tx   = mem_r[st_r.addr];
              st_nxt.addr = st_r.addr + `MEM_AW'(1);
            end
          end
          default: begin
            st_nxt.phase = PH_WAIT;
          end
        endcase
      end
    end else if (scl_fall) begin
      if (st_r.phase == PH_RD && st_r.bitcnt != `ACK_SLOT) begin
        // Most significant bit first, changed only after the fall
        st_nxt.sda_oe = !st_r.tx[~st_r.bitcnt[2:0]];
      end else if (st_r.bitcnt == `ACK_SLOT) begin
        case (st_r.phase)
          PH_DEV: begin
            // Polling during programming sees no acknowledge
            ok = (st_r.sh[7:4] == `DEV_TYPE) && (st_r.sh[3:1] == st_r.strap_s2)
              && !st_r.busy && !st_r.prog_req;
          end
          PH_AHI: begin
            ok = 1'b1;
            st_nxt.addr[`MEM_AW-1:8] = st_r.sh[`MEM_AW-9:0];
          end
          PH_ALO: begin
            ok = 1'b1;
            st_nxt.addr[7:0] = st_r.sh;
          end
          PH_WR: begin
            // A guarded array or a full queue refuses the byte
            ok = !st_r.wg_s2 && f_in_ready;
            if (ok) begin
              f_in_valid     = 1'b1;
              st_nxt.wr_seen = 1'b1;
              // Address rolls over inside the page only
              st_nxt.addr[`PAGE_AW-1:0] = st_r.addr[`PAGE_AW-1:0] + `PAGE_AW'(1);
            end
          end
          default: begin
            ok = 1'b0;
          end
        endcase
        st_nxt.ack    = ok;
        st_nxt.sda_oe = ok;
      end else begin
        st_nxt.sda_oe = 1'b0;
      end
    end

    // Page latch: only bytes actually sent get a valid mark
    if (f_out_valid && !st_r.busy) begin
      st_nxt.pbuf[f_out_data.addr[`PAGE_AW-1:0]]   = f_out_data.data;
      st_nxt.pvalid[f_out_data.addr[`PAGE_AW-1:0]] = 1'b1;
      st_nxt.page = f_out_data.addr[`MEM_AW-1:`PAGE_AW];
    end

    // Programming waits for the queue to drain, so no sent byte is lost
    if (st_r.prog_req && !f_out_valid && !st_r.busy) begin
      st_nxt.prog_req = 1'b0;
      st_nxt.busy     = 1'b1;
      st_nxt.wr_cnt   = '0;
    end

    // Self-timed write: one latch entry per cycle, then wait out the time
    if (st_r.busy) begin
      st_nxt.wr_cnt = st_r.wr_cnt + `WR_CNT_W'(1);
      if (st_r.wr_cnt < `WR_CNT_W'(`PAGE_BYTES)) begin
        mem_waddr = {st_r.page, st_r.wr_cnt[`PAGE_AW-1:0]};
        mem_wdata = st_r.pbuf[st_r.wr_cnt[`PAGE_AW-1:0]];
        // Guard raised late still keeps the array untouched
        mem_we = st_r.pvalid[st_r.wr_cnt[`PAGE_AW-1:0]] && !st_r.wg_s2;
      end
      if (st_r.wr_cnt == `WR_CNT_W'(WR_CYCLES - 1)) begin
        st_nxt.busy   = 1'b0;
        st_nxt.pvalid = '0;
      end
    end
  end

  // ==========================================================
  // Core state register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Array: non-volatile, so reset leaves it alone
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem_r[mem_waddr] <= mem_wdata;
    end
  end

endmodule

// >>> verif/bus_master.sv
/*
  Behavioural two-wire bus master: makes the serial clock, pulls the data wire.
  Assumes the bench resolves the wire: low if anyone pulls, else pulled up.
*/
`timescale 1ns/10ps

// ==========================================================
// Master model
module bus_master #(
  parameter int Q = 60
) (
  // Bus wires
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      pull_o
);
  // Idle bus: clock high, data released; the clock stands still between frames
  initial begin
    scl_o  = 1'b1;
    pull_o = 1'b0;
  end

  // Data moves mid low phase, so it never changes while the clock is high
  task automatic bit_out(input logic b);
    scl_o = 1'b0;
    #Q pull_o = ~b;
    #Q scl_o = 1'b1;
    #(2*Q) scl_o = 1'b0;
  endtask

  // Released wire is taken at the rising clock edge
  task automatic bit_in(output logic b);
    pull_o = 1'b0;
    #(2*Q) scl_o = 1'b1;
    b = sda_i;
    #(2*Q) scl_o = 1'b0;
  endtask

  // Start, or repeated start when the clock is low
  task automatic start;
    if (!scl_o) begin
      pull_o = 1'b0;
      #Q scl_o = 1'b1;
      #Q;
    end
    pull_o = 1'b1;
    #Q scl_o = 1'b0;
  endtask

  task automatic stop;
    pull_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q pull_o = 1'b0;
    #(2*Q);
  endtask

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(b);
    ack = ~b;
  endtask

  // More set means the master acknowledges and reading goes on
  task automatic get_byte(input logic more, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(~more);
  endtask
endmodule

// >>> verif/serial_eeprom_bus_pins_chk.sv
/*
  Pin checker of the EEPROM front end.
  Assumes it is bound to serial_eeprom_bus_pins and sees only its ports.
*/
`timescale 1ns/10ps
`include "eeprom_cfg.svh"

// ==========================================================
// Checker
module serial_eeprom_bus_pins_chk #(
  parameter int WR_CYCLES = 500000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Bus wires
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // Straps and guard
  input wire logic addr_strap_bit0_i,
  input wire logic addr_strap_bit1_i,
  input wire logic addr_strap_bit2_i,
  input wire logic write_guard_i
);
  logic [5:0] rises_r;
  logic [7:0] sh_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // Clock rises and bits since the last start; saturates to stay cheap
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || (scl_i && $past(scl_i) && $fell(sda_i))) begin
      rises_r <= 6'h00;
    end else if ($rose(scl_i)) begin
      rises_r <= (rises_r == 6'h3F) ? rises_r : rises_r + 6'h01;
      sh_r    <= {sh_r[6:0], sda_i};
    end
  end

  sequence s_dev_ack;
    $rose(sda_oe_o) && rises_r == 6'h08;
  endsequence
  sequence s_long_high;
    scl_i [*4];
  endsequence

  chk_open_drain: assert property (sda_o == 1'b0)
    else $error("data wire driven high");
  chk_move_low: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
    else $error("data output moved outside clock low");
  chk_hold_high: assert property (s_long_high |-> $stable(sda_oe_o))
    else $error("data output moved while clock high");
  chk_strap_match: assert property (s_dev_ack |-> sh_r[7:1] == {`DEV_TYPE,
    addr_strap_bit2_i, addr_strap_bit1_i, addr_strap_bit0_i})
    else $error("address acknowledged without strap match");
  chk_ack_held: assert property (s_dev_ack |-> sda_oe_o [*8])
    else $error("address acknowledge dropped early");
  chk_ack_slot: assert property ($rose(sda_oe_o) && rises_r < 6'h09 |-> rises_r == 6'h08)
    else $error("pull outside acknowledge slot");
  chk_guard_nack: assert property ($rose(sda_oe_o) && rises_r == 6'h23 |-> !write_guard_i)
    else $error("data byte acknowledged while guarded");
  chk_release_bound: assert property ($rose(sda_oe_o) |-> ##[1:250] !sda_oe_o)
    else $error("data wire held low too long");
endmodule

bind serial_eeprom_bus_pins serial_eeprom_bus_pins_chk #(.WR_CYCLES(WR_CYCLES)) u_chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .addr_strap_bit0_i(addr_strap_bit0_i),
  .addr_strap_bit1_i(addr_strap_bit1_i), .addr_strap_bit2_i(addr_strap_bit2_i),
  .write_guard_i(write_guard_i));

// >>> verif/serial_eeprom_bus_pins_bench.sv
/*
  Self-checking bench of the EEPROM front end against a bus master model.
  Assumes package, master model and checker are compiled before it.
*/
`timescale 1ns/10ps
`include "eeprom_cfg.svh"

// ==========================================================
// Bench top
module serial_eeprom_bus_pins_bench;
  localparam int WRC = 400;
  logic       clk_i     = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic       scl_w;
  logic       pull_w;
  logic       sda_w;
  logic       oe_w;
  logic [2:0] strap = 3'h0;
  logic       guard = 1'b0;
  logic       ack;
  logic [7:0] rd;
  logic [7:0] ref_mem [0:4095];
  logic [7:0] wq [$];
  integer     seed = 6;
  int         miscompares = 0;
  int         samples_checked = 0;
  int         cycles = 0;

  initial forever #5 clk_i = ~clk_i;
  // Unknown enable before reset counts as released
  assign sda_w = (pull_w || oe_w === 1'b1) ? 1'b0 : 1'b1;

  serial_eeprom_bus_pins #(.WR_CYCLES(WRC)) u_serial_eeprom_bus_pins (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_w), .sda_i(sda_w), .sda_o(),
    .sda_oe_o(oe_w), .addr_strap_bit0_i(strap[0]), .addr_strap_bit1_i(strap[1]),
    .addr_strap_bit2_i(strap[2]), .write_guard_i(guard));
  bus_master u_bus_master (.sda_i(sda_w), .scl_o(scl_w), .pull_o(pull_w));

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Whole run needs about 34000 cycles; past this it has hung
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      results();
    end
  end

  function automatic logic [7:0] dev_byte(input logic [2:0] s, input logic r);
    return {`DEV_TYPE, s, r};
  endfunction
  // Write address wraps inside its 32-byte page
  function automatic logic [11:0] wr_addr(input logic [11:0] a, input int i);
    return {a[11:5], a[4:0] + 5'(i)};
  endfunction

  task automatic probe(input logic [7:0] d, output logic a);
    u_bus_master.start();
    u_bus_master.put_byte(d, a);
    u_bus_master.stop();
  endtask

  task automatic send_addr(input logic [11:0] a);
    u_bus_master.start();
    u_bus_master.put_byte(dev_byte(strap, 1'b0), ack);
    check(ack, 1);
    u_bus_master.put_byte({4'h0, a[11:8]}, ack);
    u_bus_master.put_byte(a[7:0], ack);
  endtask

  task automatic write_page(input logic [11:0] a);
    send_addr(a);
    for (int i = 0; i < wq.size(); i++) begin
      u_bus_master.put_byte(wq[i], ack);
      check(ack, !guard);
      if (!guard) ref_mem[wr_addr(a, i)] = wq[i];
    end
    u_bus_master.stop();
    wq.delete();
  endtask

  // Polls with address frames; busy gives no acknowledge
  task automatic wait_ready(input logic busy_exp);
    int polls;
    polls = 0;
    ack = 1'b0;
    while (!ack && polls < 8) begin
      probe(dev_byte(strap, 1'b0), ack);
      if (polls == 0 && busy_exp) check(ack, 0);
      polls++;
    end
    check(polls <= WRC / 200 + 2, 1);
  endtask

  task automatic read_seq(input logic [11:0] a, input int n);
    send_addr(a);
    u_bus_master.start();
    u_bus_master.put_byte(dev_byte(strap, 1'b1), ack);
    check(ack, 1);
    for (int i = 0; i < n; i++) begin
      u_bus_master.get_byte(i < n - 1, rd);
      check(rd, ref_mem[a + 12'(i)]);
    end
    u_bus_master.stop();
  endtask

  // Main sequence
  initial begin
    repeat (8) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    check(oe_w, 0);
    for (int s = 0; s < 8; s++) begin
      @(negedge clk_i);
      strap = 3'(s);
      repeat (4) @(negedge clk_i);
      probe(dev_byte(strap, 1'b0), ack);
      check(ack, 1);
      probe(dev_byte(strap ^ (3'($random(seed)) | 3'h1), 1'b0), ack);
      check(ack, 0);
    end
    @(negedge clk_i);
    strap = 3'($random(seed));
    repeat (4) @(negedge clk_i);
    wq.push_back(8'($random(seed)));
    write_page(12'h000);
    wait_ready(1'b1);
    // Full page at the top, read on across the end of the array
    for (int i = 0; i < 32; i++) wq.push_back(8'($random(seed)));
    write_page(12'hFE0);
    wait_ready(1'b1);
    read_seq(12'hFE0, 33);
    // Short page write wraps at the page end and leaves the rest alone
    repeat (3) wq.push_back(8'($random(seed)));
    write_page(12'hFFE);
    wait_ready(1'b1);
    read_seq(12'hFE0, 32);
    // Guarded write is refused and the byte keeps its value
    @(negedge clk_i);
    guard = 1'b1;
    wq.push_back(~ref_mem[12'hFE5]);
    write_page(12'hFE5);
    wait_ready(1'b0);
    read_seq(12'hFE5, 1);
    // Current address read carries on after the last random read
    u_bus_master.start();
    u_bus_master.put_byte(dev_byte(strap, 1'b1), ack);
    check(ack, 1);
    u_bus_master.get_byte(1'b0, rd);
    check(rd, ref_mem[12'hFE6]);
    u_bus_master.stop();
    @(negedge clk_i);
    guard = 1'b0;
    results();
  end
endmodule
